// ---- src/ppe_engine.sv ----
// Packet engine top: register slave, send sequencer, receive verification
`timescale 1ns/1ns
module ppe_engine (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Avalon-MM slave
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Interrupt
   output logic irq_o,
   // Send byte stream
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   // Receive byte stream
   input wire logic [7:0] rx_data_i,
   input wire logic rx_valid_i
);
   // Register file and memories
   logic [31:0] ctrl_r;
   logic [31:0] tx_mon_r;
   logic [31:0] rx_wait_r;
   logic [1:0] irq_sts_r;
   logic [1:0] irq_en_r;
   logic [5:0] elem_len [ppe_pkg::NUM_ELEM];
   logic elem_isl [ppe_pkg::NUM_ELEM];
   logic [7:0] tx_mem [ppe_pkg::TX_MEM_DEPTH];
   logic [7:0] rx_pat [ppe_pkg::NUM_RX_PKT * ppe_pkg::RX_PKT_LEN];
   logic [4:0] rx_len [ppe_pkg::NUM_RX_PKT];
   // Bus handshake and interrupt output register
   logic wait_r;
   logic [31:0] rdata_r;
   logic irq_r;
   logic wr_w;
   // Engine state
   ppe_pkg::ppe_state_t state_r, state_nxt;
   logic [2:0] elem_idx_r, elem_idx_nxt;
   logic [5:0] byte_idx_r, byte_idx_nxt;
   logic [5:0] mem_ptr_r, mem_ptr_nxt;
   logic [3:0] elem_cnt_r, elem_cnt_nxt;
   logic tx_valid_r, tx_valid_nxt;
   logic [7:0] tx_data_r, tx_data_nxt;
   logic [31:0] timer_r, timer_nxt;
   logic [1:0] result_r, result_nxt;
   logic [2:0] match_r, match_nxt;
   logic ev_ok, ev_err;
   logic [1:0] irq_sts_nxt;
   logic start_w;
   logic [15:0] range_sum;
   logic [ppe_pkg::NUM_RX_PKT-1:0] hit;
   logic [3:0] pos [ppe_pkg::NUM_RX_PKT];
   logic mclr;

   wire logic [1:0] ctype = ctrl_r[ppe_pkg::CTRL_TYPE_LSB +: 2];
   wire logic [3:0] rng_start = ctrl_r[ppe_pkg::CTRL_RNG_START_LSB +: 4];
   wire logic [3:0] rng_end = ctrl_r[ppe_pkg::CTRL_RNG_END_LSB +: 4];
   wire logic [3:0] n_elem = ctrl_r[ppe_pkg::CTRL_NELEM_LSB +: 4];

   ppe_len_if len_bus ();
   ppe_len_enc u_len_enc (.len(len_bus));
   assign len_bus.value = range_sum; // R13
   assign len_bus.width = elem_len[elem_idx_r][2:0];
   assign len_bus.code = ctrl_r[ppe_pkg::CTRL_CODE_LSB +: 2];
   assign len_bus.flow = ctrl_r[ppe_pkg::CTRL_FLOW_LSB +: 2];
   assign len_bus.idx = byte_idx_r[1:0];

   // One wait state per access: request seen with waitrequest high, taken on the next edge
   assign wr_w = avs_write_i && !wait_r;
   assign start_w = wr_w && avs_address_i == ppe_pkg::ADDR_CTRL && avs_byteenable_i[0]
                    && avs_writedata_i[ppe_pkg::CTRL_START_BIT] && avs_writedata_i[ppe_pkg::CTRL_TYPE_LSB +: 2] != 2'h0;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return m;
   endfunction

   // Length over the element range, Length element at its own width
   always_comb begin
      range_sum = 16'h0;
      for (int i = 0; i < ppe_pkg::NUM_ELEM; i++) begin
         if (4'(i + 1) >= rng_start && 4'(i + 1) <= rng_end && 4'(i) < n_elem) begin
            range_sum = range_sum + {10'h0, elem_len[i]}; // R12 R13
         end
      end
   end

   // Receive trackers, one per registered packet
   assign mclr = state_r != ppe_pkg::ST_RXWAIT;
   for (genvar p = 0; p < ppe_pkg::NUM_RX_PKT; p++) begin : g_match
      ppe_rx_match u_match (
         .mclk_i(mclk_i),
         .rst_n_i(rst_n_i),
         .clr_i(mclr),
         .byte_valid_i(rx_valid_i && !mclr),
         .byte_i(rx_data_i),
         .exp_byte_i(rx_pat[p * ppe_pkg::RX_PKT_LEN + int'(pos[p])]),
         .first_byte_i(rx_pat[p * ppe_pkg::RX_PKT_LEN]),
         .pat_len_i(rx_len[p]),
         .pos_o(pos[p]),
         .hit_o(hit[p])
      );
   end

   always_comb begin
      state_nxt = state_r;
      elem_idx_nxt = elem_idx_r;
      byte_idx_nxt = byte_idx_r;
      mem_ptr_nxt = mem_ptr_r;
      elem_cnt_nxt = elem_cnt_r;
      tx_valid_nxt = tx_valid_r;
      tx_data_nxt = tx_data_r;
      timer_nxt = timer_r;
      result_nxt = result_r;
      match_nxt = match_r;
      ev_ok = 1'b0;
      ev_err = 1'b0;
      case (state_r)
         ppe_pkg::ST_IDLE: begin
            if (start_w) begin
               timer_nxt = 32'h0;
               result_nxt = ppe_pkg::RES_NONE;
               match_nxt = 3'h0;
               elem_idx_nxt = 3'h0;
               elem_cnt_nxt = 4'h0;
               byte_idx_nxt = 6'h0;
               mem_ptr_nxt = 6'h0;
               state_nxt = (avs_writedata_i[ppe_pkg::CTRL_TYPE_LSB +: 2] == ppe_pkg::TYPE_RECV)
                           ? ppe_pkg::ST_RXWAIT : ppe_pkg::ST_SEND;
            end
         end
         ppe_pkg::ST_SEND: begin
            timer_nxt = timer_r + 32'h1;
            if (tx_mon_r != 32'h0 && timer_r >= tx_mon_r) begin
               // Abort drops the byte on offer
               tx_valid_nxt = 1'b0; // R2
               result_nxt = ppe_pkg::RES_TX_TIMEOUT; // R2
               ev_err = 1'b1;
               state_nxt = ppe_pkg::ST_IDLE;
            end else if (!tx_valid_r || tx_ready_i) begin
               tx_valid_nxt = 1'b0;
               if (elem_cnt_r < n_elem) begin
                  if (elem_len[elem_idx_r] == 6'h0) begin
                     elem_idx_nxt = elem_idx_r + 3'h1;
                     elem_cnt_nxt = elem_cnt_r + 4'h1;
                  end else begin
                     tx_valid_nxt = 1'b1;
                     tx_data_nxt = elem_isl[elem_idx_r] ? len_bus.data : tx_mem[mem_ptr_r]; // R13
                     mem_ptr_nxt = elem_isl[elem_idx_r] ? mem_ptr_r : mem_ptr_r + 6'h1;
                     byte_idx_nxt = byte_idx_r + 6'h1;
                     if (byte_idx_r == elem_len[elem_idx_r] - 6'h1) begin
                        byte_idx_nxt = 6'h0;
                        elem_idx_nxt = elem_idx_r + 3'h1;
                        elem_cnt_nxt = elem_cnt_r + 4'h1;
                     end
                  end
               end else if (ctype == ppe_pkg::TYPE_BOTH) begin
                  timer_nxt = 32'h0;
                  state_nxt = ppe_pkg::ST_RXWAIT; // R4
               end else begin
                  result_nxt = ppe_pkg::RES_OK; // R1
                  ev_ok = 1'b1;
                  state_nxt = ppe_pkg::ST_IDLE; // R1
               end
            end
         end
         ppe_pkg::ST_RXWAIT: begin
            timer_nxt = timer_r + 32'h1;
            if (hit != '0) begin
               for (int p = ppe_pkg::NUM_RX_PKT - 1; p >= 0; p--) begin
                  if (hit[p]) begin
                     match_nxt = 3'(p + 1); // R6 R7
                  end
               end
               result_nxt = ppe_pkg::RES_OK; // R3 R4
               ev_ok = 1'b1;
               state_nxt = ppe_pkg::ST_IDLE;
            end else if (rx_wait_r != 32'h0 && timer_r >= rx_wait_r) begin
               result_nxt = ppe_pkg::RES_RX_TIMEOUT; // R3 R5
               ev_err = 1'b1;
               state_nxt = ppe_pkg::ST_IDLE;
            end
         end
         default: state_nxt = ppe_pkg::ST_IDLE;
      endcase
      // Set wins over a clear in the same cycle
      irq_sts_nxt = irq_sts_r;
      if (wr_w && avs_address_i == ppe_pkg::ADDR_IRQ_CLR && avs_byteenable_i[0]) begin
         irq_sts_nxt = irq_sts_r & ~avs_writedata_i[1:0];
      end
      irq_sts_nxt[ppe_pkg::IRQ_OK_BIT] = irq_sts_nxt[ppe_pkg::IRQ_OK_BIT] | ev_ok;
      irq_sts_nxt[ppe_pkg::IRQ_ERR_BIT] = irq_sts_nxt[ppe_pkg::IRQ_ERR_BIT] | ev_err;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ppe_pkg::ST_IDLE;
         elem_idx_r <= 3'h0;
         byte_idx_r <= 6'h0;
         mem_ptr_r <= 6'h0;
         elem_cnt_r <= 4'h0;
         tx_valid_r <= 1'b0;
         tx_data_r <= 8'h00;
         timer_r <= 32'h0;
         result_r <= ppe_pkg::RES_NONE;
         match_r <= 3'h0;
         irq_sts_r <= 2'h0;
         irq_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         elem_idx_r <= elem_idx_nxt;
         byte_idx_r <= byte_idx_nxt;
         mem_ptr_r <= mem_ptr_nxt;
         elem_cnt_r <= elem_cnt_nxt;
         tx_valid_r <= tx_valid_nxt;
         tx_data_r <= tx_data_nxt;
         timer_r <= timer_nxt;
         result_r <= result_nxt;
         match_r <= match_nxt;
         irq_sts_r <= irq_sts_nxt;
         irq_r <= |(irq_sts_r & irq_en_r);
      end
   end

   // Bus handshake, read mux and configuration writes
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_r <= 1'b1;
         rdata_r <= 32'h0;
         ctrl_r <= ppe_pkg::CTRL_RESET;
         tx_mon_r <= 32'h0;
         rx_wait_r <= 32'h0;
         irq_en_r <= 2'h0;
      end else begin
         wait_r <= !((avs_read_i || avs_write_i) && wait_r);
         rdata_r <= 32'h0;
         if (avs_read_i && wait_r) begin
            if (avs_address_i == ppe_pkg::ADDR_CTRL) begin
               rdata_r <= {ctrl_r[31:1], 1'b0};
            end else if (avs_address_i == ppe_pkg::ADDR_RESULT) begin
               rdata_r <= {25'h0, match_r, result_r, 1'b0, state_r != ppe_pkg::ST_IDLE}; // R7
            end else if (avs_address_i == ppe_pkg::ADDR_TX_MON) begin
               rdata_r <= tx_mon_r;
            end else if (avs_address_i == ppe_pkg::ADDR_RX_WAIT) begin
               rdata_r <= rx_wait_r;
            end else if (avs_address_i == ppe_pkg::ADDR_IRQ_STS) begin
               rdata_r <= {30'h0, irq_sts_r};
            end else if (avs_address_i == ppe_pkg::ADDR_IRQ_EN) begin
               rdata_r <= {30'h0, irq_en_r};
            end else if (avs_address_i[9:4] == ppe_pkg::ADDR_RX_LEN[9:4]) begin
               rdata_r <= {27'h0, rx_len[avs_address_i[3:2]]};
            end else if (avs_address_i[9:5] == ppe_pkg::ADDR_ELEM[9:5]) begin
               rdata_r <= {23'h0, elem_isl[avs_address_i[4:2]], 2'h0, elem_len[avs_address_i[4:2]]};
            end else if (avs_address_i[9:8] == ppe_pkg::ADDR_TX_MEM[9:8]) begin
               rdata_r <= {24'h0, tx_mem[avs_address_i[7:2]]};
            end else if (avs_address_i[9:8] == ppe_pkg::ADDR_RX_PAT[9:8]) begin
               rdata_r <= {24'h0, rx_pat[avs_address_i[7:2]]};
            end
         end
         // Control and timer writes while busy are refused; interrupt enable writes are always taken
         if (wr_w && state_r == ppe_pkg::ST_IDLE) begin
            if (avs_address_i == ppe_pkg::ADDR_CTRL) begin
               ctrl_r <= merge(ctrl_r, avs_writedata_i, avs_byteenable_i) & 32'hfffffffe;
            end else if (avs_address_i == ppe_pkg::ADDR_TX_MON) begin
               tx_mon_r <= merge(tx_mon_r, avs_writedata_i, avs_byteenable_i);
            end else if (avs_address_i == ppe_pkg::ADDR_RX_WAIT) begin
               rx_wait_r <= merge(rx_wait_r, avs_writedata_i, avs_byteenable_i);
            end
         end
         if (wr_w && avs_address_i == ppe_pkg::ADDR_IRQ_EN && avs_byteenable_i[0]) begin
            irq_en_r <= avs_writedata_i[1:0];
         end
      end
   end

   // Table memories, no reset by design
   always_ff @(posedge mclk_i) begin
      if (wr_w && state_r == ppe_pkg::ST_IDLE) begin
         if (avs_address_i[9:4] == ppe_pkg::ADDR_RX_LEN[9:4] && avs_byteenable_i[0]) begin
            rx_len[avs_address_i[3:2]] <= (avs_writedata_i[4:0] > 5'd16) ? 5'd16 : avs_writedata_i[4:0];
         end
         if (avs_address_i[9:5] == ppe_pkg::ADDR_ELEM[9:5]) begin
            if (avs_byteenable_i[0]) begin
               elem_len[avs_address_i[4:2]] <= avs_writedata_i[5:0];
            end
            if (avs_byteenable_i[1]) begin
               elem_isl[avs_address_i[4:2]] <= avs_writedata_i[ppe_pkg::ELEM_IS_LEN_BIT];
            end
         end
         if (avs_address_i[9:8] == ppe_pkg::ADDR_TX_MEM[9:8] && avs_byteenable_i[0]) begin
            tx_mem[avs_address_i[7:2]] <= avs_writedata_i[7:0];
         end
         if (avs_address_i[9:8] == ppe_pkg::ADDR_RX_PAT[9:8] && avs_byteenable_i[0]) begin
            rx_pat[avs_address_i[7:2]] <= avs_writedata_i[7:0];
         end
      end
   end

   assign avs_readdata_o = rdata_r;
   assign avs_waitrequest_o = wait_r;
   assign irq_o = irq_r;
   assign tx_data_o = tx_data_r;
   assign tx_valid_o = tx_valid_r;
endmodule

// ---- src/ppe_pkg.sv ----
// Constants, register map and encodings of the packet engine
// How it works
// R1: Send-only sends the selected packet exactly once and then ends the execution.
// R2: Send-only with a nonzero monitoring time ends with a transmit timeout error if sending overruns it.
// R3: Receive-only ends normally only after a receive packet matched, otherwise, with a nonzero wait time, with a receive wait timeout.
// R4: Send-and-receive sends first and waits for receive data only after a normal send completion.
// R5: Send-and-receive with no matching data in time ends with a receive wait timeout error.
// R6: Incoming data are checked against the receive packets in registration order and the first match wins.
// R7: The number of the matched receive packet is kept in the result data for the host to read.
// R8: On a diverging byte the partial data are dropped and comparison restarts from the packet start.
// R9: Forward flow emits the length most significant first in 1 to 4 bytes as ASCII hex, ASCII decimal or HEX.
// R10: Reverse flow emits the forward length bytes in reversed order, for widths 2 to 4 only.
// R11: Byte-swap flow, 4-byte width only, swaps the two bytes within each 16-bit half.
// R12: The length is counted over a range of packet elements given by start and end element numbers.
// R13: All bytes of the elements in range are counted as sent and the encoded count fills the Length element.
package ppe_pkg;
   // Word-aligned byte addresses
   localparam logic [9:0] ADDR_CTRL = 10'h000;
   localparam logic [9:0] ADDR_RESULT = 10'h004;
   localparam logic [9:0] ADDR_TX_MON = 10'h008;
   localparam logic [9:0] ADDR_RX_WAIT = 10'h00c;
   localparam logic [9:0] ADDR_IRQ_STS = 10'h010;
   localparam logic [9:0] ADDR_IRQ_CLR = 10'h014;
   localparam logic [9:0] ADDR_IRQ_EN = 10'h018;
   localparam logic [9:0] ADDR_RX_LEN = 10'h020;
   localparam logic [9:0] ADDR_ELEM = 10'h040;
   localparam logic [9:0] ADDR_TX_MEM = 10'h100;
   localparam logic [9:0] ADDR_RX_PAT = 10'h200;
   // Sizes
   localparam int NUM_ELEM = 8;
   localparam int TX_MEM_DEPTH = 64;
   localparam int NUM_RX_PKT = 4;
   localparam int RX_PKT_LEN = 16;
   // Control register fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_TYPE_LSB = 1;
   localparam int CTRL_CODE_LSB = 3;
   localparam int CTRL_FLOW_LSB = 5;
   localparam int CTRL_RNG_START_LSB = 8;
   localparam int CTRL_RNG_END_LSB = 12;
   localparam int CTRL_NELEM_LSB = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0001_1100;
   // Element entry fields
   localparam int ELEM_IS_LEN_BIT = 8;
   // Result register fields
   localparam int RES_BUSY_BIT = 0;
   localparam int RES_CODE_LSB = 2;
   localparam int RES_MATCH_LSB = 4;
   // Interrupt bits
   localparam int IRQ_OK_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   // Communication types
   localparam logic [1:0] TYPE_SEND = 2'h1;
   localparam logic [1:0] TYPE_RECV = 2'h2;
   localparam logic [1:0] TYPE_BOTH = 2'h3;
   // Length code types
   localparam logic [1:0] CODE_HEX = 2'h0;
   localparam logic [1:0] CODE_ASCII_HEX = 2'h1;
   localparam logic [1:0] CODE_ASCII_DEC = 2'h2;
   // Length data flows
   localparam logic [1:0] FLOW_FWD = 2'h0;
   localparam logic [1:0] FLOW_REV = 2'h1;
   localparam logic [1:0] FLOW_SWAP = 2'h2;
   // Completion codes
   localparam logic [1:0] RES_NONE = 2'h0;
   localparam logic [1:0] RES_OK = 2'h1;
   localparam logic [1:0] RES_TX_TIMEOUT = 2'h2;
   localparam logic [1:0] RES_RX_TIMEOUT = 2'h3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_RXWAIT = 2'b10
   } ppe_state_t;
endpackage

// ---- src/ppe_len_if.sv ----
// Carrier between the engine and the length encoder
`timescale 1ns/1ns
interface ppe_len_if;
   logic [15:0] value;
   logic [2:0] width;
   logic [1:0] code;
   logic [1:0] flow;
   logic [1:0] idx;
   logic [7:0] data;
   modport user (output value, width, code, flow, idx, input data);
   modport enc (input value, width, code, flow, idx, output data);
endinterface

// ---- src/ppe_len_enc.sv ----
// Length element encoder: one output byte per index
`timescale 1ns/1ns
module ppe_len_enc (
   ppe_len_if.enc len
);
   logic [7:0] fwd [4];
   logic [3:0] nib;
   logic [15:0] dec_v;
   logic [1:0] pos;
   logic [1:0] sel;
   logic [2:0] w;

   always_comb begin
      w = (len.width == 3'h0 || len.width > 3'h4) ? 3'h4 : len.width;
      dec_v = 16'h0;
      nib = 4'h0;
      pos = 2'h0;
      for (int i = 0; i < 4; i++) begin
         fwd[i] = 8'h00;
         if (3'(i) < w) begin
            // Digit position from the low end; digits that do not fit drop out
            pos = 2'(w - 3'(i) - 3'h1);
            nib = 4'(len.value >> (4 * pos));
            dec_v = len.value;
            for (int k = 0; k < 3; k++) begin
               if (2'(k) < pos) begin
                  dec_v = dec_v / 16'd10;
               end
            end
            case (len.code)
               ppe_pkg::CODE_ASCII_HEX: fwd[i] = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib}); // R9
               ppe_pkg::CODE_ASCII_DEC: fwd[i] = 8'h30 + 8'(dec_v % 16'd10); // R9
               default: fwd[i] = 8'(len.value >> (8 * pos)); // R9
            endcase
         end
      end
      sel = len.idx;
      if (len.flow == ppe_pkg::FLOW_REV && w >= 3'h2) begin
         sel = 2'(w - 3'h1 - {1'b0, len.idx}); // R10
      end else if (len.flow == ppe_pkg::FLOW_SWAP && w == 3'h4) begin
         sel = {len.idx[1], ~len.idx[0]}; // R11
      end
      len.data = fwd[sel];
   end
endmodule

// ---- src/ppe_rx_match.sv ----
// Progress tracker of one receive packet against the incoming bytes
`timescale 1ns/1ns
module ppe_rx_match (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic clr_i,
   // Incoming byte and pattern
   input wire logic byte_valid_i,
   input wire logic [7:0] byte_i,
   input wire logic [7:0] exp_byte_i,
   input wire logic [7:0] first_byte_i,
   input wire logic [4:0] pat_len_i,
   // Progress
   output logic [3:0] pos_o,
   output logic hit_o
);
   logic [3:0] pos_r;
   logic [3:0] pos_nxt;

   assign pos_o = pos_r;
   assign hit_o = byte_valid_i && pat_len_i != 5'h0 && byte_i == exp_byte_i && {1'b0, pos_r} == pat_len_i - 5'h1;

   always_comb begin
      pos_nxt = pos_r;
      if (clr_i || hit_o) begin
         pos_nxt = 4'h0;
      end else if (byte_valid_i && pat_len_i != 5'h0) begin
         if (byte_i == exp_byte_i) begin
            pos_nxt = pos_r + 4'h1;
         end else if (byte_i == first_byte_i && pat_len_i > 5'h1) begin
            // Diverging byte may itself open a new packet
            pos_nxt = 4'h1; // R8
         end else begin
            pos_nxt = 4'h0; // R8
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pos_r <= 4'h0;
      end else begin
         pos_r <= pos_nxt;
      end
   end
endmodule

// ---- verification/ppe_engine_checker.sv ----
// Port-level assertions of the packet engine
`timescale 1ns/1ns
module ppe_engine_checker (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Register bus
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // Interrupt and send stream
   input wire logic irq_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_valid_o,
   input wire logic tx_ready_i
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   property p_ws_answer;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
   endproperty
   a_ws_answer: assert property (p_ws_answer) else $error("no one-cycle answer");
   property p_ws_cause;
      !avs_read_i && !avs_write_i |=> avs_waitrequest_o;
   endproperty
   a_ws_cause: assert property (p_ws_cause) else $error("answer without request");
   property p_rd_idle;
      avs_waitrequest_o |-> avs_readdata_o == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
   property p_rd_wr;
      avs_write_i && !avs_waitrequest_o |-> avs_readdata_o == 32'h0;
   endproperty
   a_rd_wr: assert property (p_rd_wr) else $error("read data on write");
   property p_clr_ro;
      avs_read_i && !avs_waitrequest_o && avs_address_i == ppe_pkg::ADDR_IRQ_CLR |-> avs_readdata_o == 32'h0;
   endproperty
   a_clr_ro: assert property (p_clr_ro) else $error("clear register not zero");
   property p_start_ro;
      avs_read_i && !avs_waitrequest_o && avs_address_i == ppe_pkg::ADDR_CTRL |-> !avs_readdata_o[0];
   endproperty
   a_start_ro: assert property (p_start_ro) else $error("start bit reads one");
   property p_tx_hold;
      tx_valid_o && !tx_ready_i |=> !tx_valid_o || $stable(tx_data_o);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("stalled byte changed");
   property p_irq_fall;
      $fell(irq_o) |-> $past(avs_write_i, 2) || $past(avs_write_i, 3);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule
bind ppe_engine ppe_engine_checker u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
   .tx_ready_i(tx_ready_i));

// ---- verification/ppe_far.sv ----
// Far-side serial device: byte sink with stalls, byte source
`timescale 1ns/1ns
module ppe_far (
   // Clock
   input wire logic mclk_i,
   // Send stream from the engine
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   // Receive stream to the engine
   output logic [7:0] rx_data_o,
   output logic rx_valid_o
);
   logic [7:0] got[$];
   logic stall = 1'b0;
   initial begin
      tx_ready_o = 1'b0;
      rx_data_o = 8'h00;
      rx_valid_o = 1'b0;
   end
   // Random stalls so held bytes get exercised
   always @(posedge mclk_i) begin
      if (tx_valid_i && tx_ready_o)
         got.push_back(tx_data_i);
      tx_ready_o <= !stall && ($urandom_range(3, 0) != 0);
   end
   // Idle line shows the inverse, not a stale copy
   task automatic push(input logic [7:0] b);
      @(posedge mclk_i);
      rx_data_o <= b;
      rx_valid_o <= 1'b1;
      @(posedge mclk_i);
      rx_valid_o <= 1'b0;
      rx_data_o <= ~b;
   endtask
endmodule

// ---- verification/ppe_engine_bench.sv ----
// Self-checking bench of the packet engine
`timescale 1ns/1ns
module ppe_engine_bench;
   logic mclk_i = 0, rst_n_i = 0, rd = 0, wr = 0, wt, irq, txv, txr, rxv;
   logic [9:0] adr = 0;
   logic [31:0] wd = 0, rdat, r;
   logic [7:0] txd, rxd;
   logic [7:0] mem[64];
   int n_errors = 0, check_count = 0, cyc = 0, c, f, w;
   always #50 mclk_i = ~mclk_i;
   ppe_engine u_ppe_engine (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wt), .irq_o(irq), .tx_data_o(txd), .tx_valid_o(txv), .tx_ready_i(txr),
      .rx_data_i(rxd), .rx_valid_i(rxv));
   ppe_far u_ppe_far (.mclk_i(mclk_i), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr),
      .rx_data_o(rxd), .rx_valid_o(rxv));
   task end_sim;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc > 40000) begin
         n_errors++;
         end_sim;
      end
   end
   task automatic chk(input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic bw(input logic [9:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      do @(posedge mclk_i); while (wt !== 1'b0);
      wr <= 1'b0;
   endtask
   task automatic br(input logic [9:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      adr <= a;
      rd <= 1'b1;
      do @(posedge mclk_i); while (wt !== 1'b0);
      d = rdat;
      rd <= 1'b0;
   endtask
   // Length bytes in send order, byte k at bits 8k+7:8k
   function automatic logic [31:0] enc(input int v, w, c, f);
      logic [31:0] b, o;
      int k, p, n;
      b = 32'h0;
      for (k = 0; k < w; k++) begin
         p = w - 1 - k;
         n = (v >> (4 * p)) & 15;
         if (c == 0) b[8*k+:8] = 8'(v >> (8 * p));
         else if (c == 1) b[8*k+:8] = (n < 10) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
         else b[8*k+:8] = 8'h30 + 8'((v / (10 ** p)) % 10);
      end
      o = b;
      if (f == 1 && w > 1)
         for (k = 0; k < w; k++) o[8*k+:8] = b[8*(w-1-k)+:8];
      if (f == 2 && w == 4)
         o = {b[23:16], b[31:24], b[7:0], b[15:8]};
      return o;
   endfunction
   // Header 2 bytes, Length w bytes, data d bytes; range s..3
   task automatic snd(input int d, w, c, f, s, ty);
      logic [7:0] ex[$];
      logic [31:0] lb;
      int k;
      u_ppe_far.got.delete();
      bw(ppe_pkg::ADDR_ELEM, 32'h2);
      bw(ppe_pkg::ADDR_ELEM + 10'h4, 32'h100 | w);
      bw(ppe_pkg::ADDR_ELEM + 10'h8, d);
      for (k = 0; k < 2 + d; k++) begin
         mem[k] = 8'($urandom);
         bw(ppe_pkg::ADDR_TX_MEM + 10'(4 * k), {24'h0, mem[k]});
      end
      lb = enc((s <= 1 ? 2 : 0) + (s <= 2 ? w : 0) + d, w, c, f);
      ex = {mem[0], mem[1]};
      for (k = 0; k < w; k++) ex.push_back(lb[8*k+:8]);
      for (k = 0; k < d; k++) ex.push_back(mem[2+k]);
      bw(ppe_pkg::ADDR_CTRL, 32'h3_3001 | s << 8 | f << 5 | c << 3 | ty << 1);
      for (k = 0; k < 400 && u_ppe_far.got.size() < ex.size(); k++) @(posedge mclk_i);
      foreach (ex[k]) chk(u_ppe_far.got[k], ex[k]);
   endtask
   task automatic fin(input logic [31:0] e);
      logic [31:0] q = 32'h1;
      for (int k = 0; k < 300 && q[0] !== 1'b0; k++) br(ppe_pkg::ADDR_RESULT, q);
      chk(q, e);
   endtask
   initial begin
      void'($urandom(23881));
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      br(ppe_pkg::ADDR_CTRL, r);
      chk(r, ppe_pkg::CTRL_RESET);
      br(10'h3fc, r);
      chk(r, 32'h0);
      br(ppe_pkg::ADDR_IRQ_CLR, r);
      chk(r, 32'h0);
      bw(ppe_pkg::ADDR_IRQ_EN, 32'h3);
      bw(ppe_pkg::ADDR_RX_WAIT, 32'd200);
      for (c = 0; c < 3; c++)
         for (f = 0; f < 3; f++)
            for (w = 1; w < 5; w++) begin
               snd($urandom_range(20, 1), w, c, f, $urandom_range(3, 1), 1);
               fin(32'h4);
            end
      chk(irq, 1'b1);
      // Stalled sink forces the send monitor to expire
      u_ppe_far.stall = 1'b1;
      bw(ppe_pkg::ADDR_TX_MON, 32'd10);
      bw(ppe_pkg::ADDR_CTRL, 32'h3_3003);
      fin(32'h8);
      u_ppe_far.stall = 1'b0;
      bw(ppe_pkg::ADDR_TX_MON, 32'h0);
      for (c = 0; c < 6; c++) begin
         bw(ppe_pkg::ADDR_RX_PAT + 10'(64 * (c / 2) + 4 * (c % 2)), (c < 2 ? 32'h51 : 32'h53) + c % 2);
         if (c < 4) bw(ppe_pkg::ADDR_RX_LEN + 10'(4 * c), c < 3 ? 32'h2 : 32'h0);
      end
      bw(ppe_pkg::ADDR_IRQ_CLR, 32'h3);
      bw(ppe_pkg::ADDR_CTRL, 32'h5);
      for (c = 0; c < 4; c++) u_ppe_far.push(c[0] ? 8'h55 - c[1] : 8'h53);
      fin(32'h24);
      bw(ppe_pkg::ADDR_IRQ_CLR, 32'h3);
      bw(ppe_pkg::ADDR_RX_WAIT, 32'd20);
      bw(ppe_pkg::ADDR_CTRL, 32'h5);
      u_ppe_far.push(8'h51);
      fin(32'hc);
      br(ppe_pkg::ADDR_IRQ_STS, r);
      chk(r, 32'h2);
      chk(irq, 1'b1);
      bw(ppe_pkg::ADDR_IRQ_EN, 32'h1);
      repeat (2) @(posedge mclk_i);
      chk(irq, 1'b0);
      bw(ppe_pkg::ADDR_IRQ_CLR, 32'h3);
      br(ppe_pkg::ADDR_IRQ_STS, r);
      chk(r, 32'h0);
      bw(ppe_pkg::ADDR_RX_WAIT, 32'd200);
      snd(5, 2, 1, 1, 1, 3);
      u_ppe_far.push(8'h51);
      u_ppe_far.push(8'h52);
      fin(32'h14);
      bw(ppe_pkg::ADDR_RX_WAIT, 32'd20);
      snd(3, 4, 0, 2, 2, 3);
      fin(32'hc);
      end_sim;
   end
endmodule
